// *** inc/jump_pkg.sv ***
// Constants and types shared by the conditional jump unit and its word collector.
// Assumes command words arrive one 16-bit word at a time from the program buffer.
package jump_pkg;
    localparam logic [15:0] CMD_AND_INPUTS = 16'h00fa;
    localparam logic [15:0] CMD_REG_COMPARE = 16'h0089;
    localparam logic [2:0] LEN_AND_INPUTS = 3'h4;
    localparam logic [2:0] LEN_REG_COMPARE = 3'h5;
    localparam logic [7:0] OP_REG_EQ = 8'h00;
    localparam logic [7:0] OP_REG_GE = 8'h01;
    localparam logic [7:0] OP_REG_LT = 8'h02;
    localparam logic [7:0] OP_REG_NE = 8'h03;
    localparam logic [7:0] OP_REG_GT = 8'h04;
    localparam logic [7:0] OP_REG_LE = 8'h05;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [2:0] WORD_IDX_RESET = 3'h0;
    typedef enum {ST_IDLE, ST_COLLECT, ST_REG_WAIT, ST_DECIDE} jump_state_t;
endpackage

// *** inc/word_bus_if.sv ***
// Interface carrying collected command words between collector and decoder.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface word_bus_if;
    logic [15:0] words [0:4];
    logic [2:0] count;
    logic done;
    logic clear;
    modport collector (output words, output count, output done, input clear);
    modport decoder (input words, input count, input done, output clear);
endinterface
`default_nettype wire

// *** rtl/jump_word_collector.sv ***
// Gathers the words of one jump command in order, opcode word first.
// Assumes the word strobe is a one-cycle pulse with valid data beside it.
`timescale 1ns/1ps
`default_nettype none
module jump_word_collector (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic word_valid,
    input wire logic [15:0] word_data,
    input wire logic [2:0] expected_len,
    word_bus_if.collector bus
);
    logic [15:0] words_reg [0:4];
    logic [2:0] count_reg;
    logic done_reg;
    wire logic last_word = word_valid && (count_reg + 3'h1 == expected_len);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= jump_pkg::WORD_IDX_RESET;
            done_reg <= 1'b0;
        end else if (bus.clear) begin
            count_reg <= jump_pkg::WORD_IDX_RESET;
            done_reg <= 1'b0;
        end else if (word_valid && !done_reg) begin
            count_reg <= count_reg + 3'h1;
            done_reg <= last_word;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_word
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    words_reg[gi] <= 16'h0000;
                end else if (word_valid && !done_reg && count_reg == 3'(gi)) begin
                    words_reg[gi] <= word_data;
                end
            end
            assign bus.words[gi] = words_reg[gi];
        end
    endgenerate

    assign bus.count = count_reg;
    assign bus.done = done_reg;
endmodule
`default_nettype wire

// *** rtl/conditional_jump_unit.sv ***
// Conditional jump unit: decodes the I/O-state jump and register-compare jumps.
// Assumes the sequencer feeds command words and supplies register contents on request.
// How it works
// - Enable mask picks input bits that count.
// - State word gives expected level per input.
// - All enabled inputs must match to jump.
// - Zero mask and zero state always jump.
// - I/O jump is command 250, four words.
// - Compare jumps share 137; high byte picks.
// - Operation 1 jumps on register >= value.
// - Operation 4 jumps on register > value.
// - True condition loads the given target address.
`timescale 1ns/1ps
`default_nettype none
module conditional_jump_unit (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic WORD_VALID,
    input wire logic [15:0] WORD_DATA,
    input wire logic [15:0] CMD_ADDR,
    input wire logic [15:0] INPUT_STATE_WORD,
    input wire logic [31:0] REG_DATA,
    input wire logic REG_DATA_VALID,
    output logic [7:0] REG_SELECT,
    output logic REG_READ,
    output logic [15:0] NEXT_PC,
    output logic PC_LOAD,
    output logic JUMP_TAKEN,
    output logic BUSY,
    output logic BAD_COMMAND
);
    word_bus_if bus ();
    jump_pkg::jump_state_t state_reg, state_next;
    logic [15:0] base_pc_reg;
    logic [31:0] reg_value_reg;
    logic [7:0] reg_select_reg;
    logic reg_read_reg, pc_load_reg, taken_reg, bad_reg, clear_reg;
    logic busy_reg;
    logic [15:0] next_pc_reg;
    logic [2:0] len_reg;

    // Command number decode, used on the first word and on the stored one.
    function automatic logic [2:0] cmd_length(input logic [15:0] cmd);
        if (cmd == jump_pkg::CMD_AND_INPUTS) begin
            return jump_pkg::LEN_AND_INPUTS;
        end else if (cmd == jump_pkg::CMD_REG_COMPARE) begin
            return jump_pkg::LEN_REG_COMPARE;
        end
        return 3'h0;
    endfunction

    jump_word_collector u_collect (
        .clk(MCLK),
        .rst_b(RST_B),
        .word_valid(WORD_VALID && state_reg != jump_pkg::ST_REG_WAIT
            && state_reg != jump_pkg::ST_DECIDE && cmd_length(WORD_DATA) != 3'h0
            || WORD_VALID && state_reg == jump_pkg::ST_COLLECT),
        .word_data(WORD_DATA),
        .expected_len(len_reg == 3'h0 ? cmd_length(WORD_DATA) : len_reg),
        .bus(bus)
    );

    wire logic is_and_cmd = cmd_length(bus.words[0]) == jump_pkg::LEN_AND_INPUTS;
    wire logic [15:0] enable_mask = bus.words[1];
    wire logic [15:0] expect_state = bus.words[2];
    wire logic inputs_match = ((INPUT_STATE_WORD ^ expect_state) & enable_mask) == 16'h0000;
    wire logic unconditional = enable_mask == 16'h0000 && expect_state == 16'h0000;
    wire logic and_true = unconditional || inputs_match;
    wire logic [7:0] op_code = bus.words[1][15:8];
    wire logic [7:0] reg_num = bus.words[1][7:0];
    wire logic signed [31:0] cmp_value = {bus.words[2], bus.words[3]};
    wire logic signed [31:0] reg_signed = reg_value_reg;
    wire logic op_known = op_code <= jump_pkg::OP_REG_LE;
    logic cmp_true;
    always_comb begin
        case (op_code)
            jump_pkg::OP_REG_EQ: cmp_true = reg_signed == cmp_value;
            jump_pkg::OP_REG_GE: cmp_true = reg_signed >= cmp_value;
            jump_pkg::OP_REG_LT: cmp_true = reg_signed < cmp_value;
            jump_pkg::OP_REG_NE: cmp_true = reg_signed != cmp_value;
            jump_pkg::OP_REG_GT: cmp_true = reg_signed > cmp_value;
            jump_pkg::OP_REG_LE: cmp_true = reg_signed <= cmp_value;
            default: cmp_true = 1'b0;
        endcase
    end
    wire logic cond_true = is_and_cmd ? and_true : cmp_true;
    wire logic [15:0] target = is_and_cmd ? bus.words[3] : bus.words[4];
    wire logic [15:0] fall_through = base_pc_reg + 16'(len_reg);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            jump_pkg::ST_IDLE: begin
                if (WORD_VALID && cmd_length(WORD_DATA) != 3'h0) begin
                    state_next = jump_pkg::ST_COLLECT;
                end
            end
            jump_pkg::ST_COLLECT: begin
                if (bus.done) begin
                    state_next = is_and_cmd ? jump_pkg::ST_DECIDE : jump_pkg::ST_REG_WAIT;
                end
            end
            jump_pkg::ST_REG_WAIT: begin
                if (REG_DATA_VALID) begin
                    state_next = jump_pkg::ST_DECIDE;
                end
            end
            jump_pkg::ST_DECIDE: state_next = jump_pkg::ST_IDLE;
            default: state_next = jump_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= jump_pkg::ST_IDLE;
            len_reg <= 3'h0;
            base_pc_reg <= jump_pkg::PC_RESET;
        end else begin
            state_reg <= state_next;
            if (state_reg == jump_pkg::ST_IDLE && state_next == jump_pkg::ST_COLLECT) begin
                len_reg <= cmd_length(WORD_DATA);
                base_pc_reg <= CMD_ADDR;
            end else if (state_reg == jump_pkg::ST_DECIDE) begin
                len_reg <= 3'h0;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            reg_select_reg <= 8'h00;
            reg_read_reg <= 1'b0;
            reg_value_reg <= 32'h0000_0000;
        end else begin
            reg_read_reg <= state_reg == jump_pkg::ST_COLLECT && state_next == jump_pkg::ST_REG_WAIT;
            if (state_reg == jump_pkg::ST_COLLECT && bus.done) begin
                reg_select_reg <= reg_num;
            end
            if (state_reg == jump_pkg::ST_REG_WAIT && REG_DATA_VALID) begin
                reg_value_reg <= REG_DATA;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            next_pc_reg <= jump_pkg::PC_RESET;
            pc_load_reg <= 1'b0;
            taken_reg <= 1'b0;
            bad_reg <= 1'b0;
            clear_reg <= 1'b0;
        end else begin
            pc_load_reg <= state_reg == jump_pkg::ST_DECIDE;
            clear_reg <= state_reg == jump_pkg::ST_DECIDE;
            if (state_reg == jump_pkg::ST_DECIDE) begin
                taken_reg <= cond_true;
                bad_reg <= !is_and_cmd && !op_known;
                next_pc_reg <= cond_true ? target : fall_through;
            end
        end
    end

    // Busy is registered so that the port comes straight from a flip-flop.
    // It covers the command in flight and the one cycle in which the
    // collector is cleared, so a new command cannot lose its first word.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= state_next != jump_pkg::ST_IDLE || state_reg == jump_pkg::ST_DECIDE;
        end
    end

    assign bus.clear = clear_reg;
    assign REG_SELECT = reg_select_reg;
    assign REG_READ = reg_read_reg;
    assign NEXT_PC = next_pc_reg;
    assign PC_LOAD = pc_load_reg;
    assign JUMP_TAKEN = taken_reg;
    assign BAD_COMMAND = bad_reg;
    assign BUSY = busy_reg;
endmodule
`default_nettype wire

// *** testbench/conditional_jump_unit_checker.sv ***
// Timing checks on the conditional jump unit's ports.
// Assumes one clock, MCLK, and the asynchronous active-low reset RST_B.
`timescale 1ns/1ps
`default_nettype none
module conditional_jump_unit_checker (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic WORD_VALID,
    input wire logic [15:0] WORD_DATA,
    input wire logic [15:0] CMD_ADDR,
    input wire logic REG_READ,
    input wire logic REG_DATA_VALID,
    input wire logic [15:0] NEXT_PC,
    input wire logic PC_LOAD,
    input wire logic JUMP_TAKEN,
    input wire logic BUSY
);
    logic [15:0] cmd_reg;
    logic [15:0] addr_reg;
    wire is_jump = (WORD_DATA == jump_pkg::CMD_AND_INPUTS) ||
        (WORD_DATA == jump_pkg::CMD_REG_COMPARE);
    wire [15:0] fall_pc = addr_reg + ((cmd_reg == jump_pkg::CMD_AND_INPUTS) ? 16'h0004 : 16'h0005);
    // The first word of a command is remembered so fall-through can be judged.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            cmd_reg <= 16'h0000;
            addr_reg <= 16'h0000;
        end else if (WORD_VALID && !BUSY && is_jump) begin
            cmd_reg <= WORD_DATA;
            addr_reg <= CMD_ADDR;
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    a_load_one_cycle: assert property (PC_LOAD |=> !PC_LOAD)
        else $error("PC_LOAD held past one cycle");
    a_read_one_cycle: assert property (REG_READ |=> !REG_READ)
        else $error("REG_READ held past one cycle");
    a_read_on_compare: assert property (REG_READ |-> cmd_reg == jump_pkg::CMD_REG_COMPARE)
        else $error("REG_READ outside a compare jump");
    a_answer_delay: assert property (REG_DATA_VALID && BUSY |-> ##2 PC_LOAD)
        else $error("no PC_LOAD two cycles after register data");
    a_target_holds: assert property (!PC_LOAD |-> $stable(NEXT_PC))
        else $error("NEXT_PC changed without PC_LOAD");
    a_result_holds: assert property (!PC_LOAD |-> $stable(JUMP_TAKEN))
        else $error("JUMP_TAKEN changed without PC_LOAD");
    a_fall_through: assert property (PC_LOAD && !JUMP_TAKEN |-> NEXT_PC == fall_pc)
        else $error("fall-through address wrong");
    a_busy_ends: assert property (PC_LOAD |-> ##[1:2] !BUSY)
        else $error("BUSY still high after decision");
endmodule
`default_nettype wire

// *** testbench/reg_file_model.sv ***
// Register file answering the unit's register read requests.
// Assumes the bench sets the value to return and the answer lag in cycles.
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
    input wire logic MCLK,
    input wire logic REG_READ,
    input wire logic [31:0] value,
    input wire logic [3:0] lag,
    output logic [31:0] REG_DATA,
    output logic REG_DATA_VALID
);
    initial begin
        REG_DATA = 32'h5a5a5a5a;
        REG_DATA_VALID = 1'b0;
    end
    // Outside the answer cycle the data lines show 5a5a5a5a before the first answer and the inverse of the value after it.
    always @(posedge MCLK) begin
        if (REG_READ === 1'b1) begin
            repeat (lag) @(posedge MCLK);
            #1 REG_DATA = value;
            REG_DATA_VALID = 1'b1;
            @(posedge MCLK);
            #1 REG_DATA = ~value;
            REG_DATA_VALID = 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** testbench/conditional_jump_unit_tb.sv ***
// Self-checking bench for the conditional jump unit.
// Assumes the checker and register file model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module conditional_jump_unit_tb;
    logic MCLK = 1'b0, RST_B = 1'b0, WORD_VALID = 1'b0, REG_DATA_VALID, REG_READ;
    logic [15:0] WORD_DATA = 16'h0000, CMD_ADDR = 16'h0020, INPUT_STATE_WORD = 16'h0000;
    logic [31:0] REG_DATA, reg_value = 32'h0;
    logic [3:0] lag = 4'h0;
    logic [7:0] REG_SELECT;
    logic [15:0] NEXT_PC;
    logic PC_LOAD, JUMP_TAKEN, BUSY, BAD_COMMAND;
    int fail_count = 0, tests_run = 0, cycles = 0;
    conditional_jump_unit DUT (.MCLK(MCLK), .RST_B(RST_B), .WORD_VALID(WORD_VALID),
        .WORD_DATA(WORD_DATA), .CMD_ADDR(CMD_ADDR), .INPUT_STATE_WORD(INPUT_STATE_WORD),
        .REG_DATA(REG_DATA), .REG_DATA_VALID(REG_DATA_VALID), .REG_SELECT(REG_SELECT),
        .REG_READ(REG_READ), .NEXT_PC(NEXT_PC), .PC_LOAD(PC_LOAD), .JUMP_TAKEN(JUMP_TAKEN),
        .BUSY(BUSY), .BAD_COMMAND(BAD_COMMAND));
    reg_file_model partner (.MCLK(MCLK), .REG_READ(REG_READ), .value(reg_value), .lag(lag),
        .REG_DATA(REG_DATA), .REG_DATA_VALID(REG_DATA_VALID));
    always #12.5 MCLK = ~MCLK;
    task automatic complete_run();
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            complete_run();
        end
    end
    // Feeds one command, waits for the decision and judges it.
    task automatic run(input logic [15:0] w [0:4], input int n, input logic [15:0] io,
        input logic [31:0] rv, input logic take);
        logic [15:0] exp_pc;
        int i;
        CMD_ADDR = CMD_ADDR + 16'h0013;
        exp_pc = take ? w[n-1] : CMD_ADDR + 16'(n);
        INPUT_STATE_WORD = io;
        reg_value = rv;
        for (i = 0; i < n; i++) begin
            WORD_DATA = w[i];
            WORD_VALID = 1'b1;
            @(posedge MCLK);
            #1;
        end
        WORD_VALID = 1'b0;
        WORD_DATA = ~WORD_DATA;
        for (i = 0; i < 40 && PC_LOAD !== 1'b1; i++) @(negedge MCLK);
        `CHK("PC_LOAD", 1'b1, PC_LOAD)
        `CHK("JUMP_TAKEN", take, JUMP_TAKEN)
        `CHK("NEXT_PC", exp_pc, NEXT_PC)
        if (n == 5) `CHK("REG_SELECT", w[1][7:0], REG_SELECT)
        `CHK("BAD_COMMAND", 1'(n == 5 && w[1][15:8] > 8'h05), BAD_COMMAND)
        @(posedge MCLK);
        #1;
        for (i = 0; i < 10 && BUSY !== 1'b0; i++) @(posedge MCLK) #1;
    endtask
    task automatic t_io_and();
        run('{16'h00fa, 16'hf000, 16'hf000, 16'h000a, 16'h0}, 4, 16'hf0f0, 0, 1);
        run('{16'h00fa, 16'hf000, 16'hf000, 16'h000a, 16'h0}, 4, 16'h70f0, 0, 0);
        run('{16'h00fa, 16'h00ff, 16'h00a5, 16'h0031, 16'h0}, 4, 16'h5aa5, 0, 1);
        run('{16'h00fa, 16'h00ff, 16'h00a5, 16'h0031, 16'h0}, 4, 16'h00a4, 0, 0);
    endtask
    task automatic t_io_zero();
        run('{16'h00fa, 16'h0000, 16'h0000, 16'h0077, 16'h0}, 4, 16'hffff, 0, 1);
        run('{16'h00fa, 16'h0000, 16'h0000, 16'h0078, 16'h0}, 4, 16'h0000, 0, 1);
    endtask
    task automatic t_cmp_ge();
        lag = 4'h0;
        run('{16'h0089, 16'h0120, 16'h0000, 16'h04b0, 16'h000a}, 5, 0, 1200, 1);
        lag = 4'h3;
        run('{16'h0089, 16'h0120, 16'h0000, 16'h04b0, 16'h000a}, 5, 0, 1199, 0);
    endtask
    task automatic t_cmp_gt();
        lag = 4'h1;
        run('{16'h0089, 16'h0420, 16'h0000, 16'h04b0, 16'h000b}, 5, 0, 1200, 0);
        run('{16'h0089, 16'h0407, 16'h0000, 16'h04b0, 16'h000c}, 5, 0, 1201, 1);
        run('{16'h0089, 16'h04fe, 16'hffff, 16'hfffa, 16'h000d}, 5, 0, -5, 1);
        run('{16'h0089, 16'h04fe, 16'hffff, 16'hfffa, 16'h000e}, 5, 0, -7, 0);
    endtask
    // The other compare codes and an unknown one share the command number.
    task automatic t_cmp_other();
        lag = 4'h2;
        run('{16'h0089, 16'h0020, 16'h0000, 16'h04b0, 16'h0010}, 5, 0, 1200, 1);
        run('{16'h0089, 16'h0220, 16'h0000, 16'h04b0, 16'h0011}, 5, 0, 1200, 0);
        run('{16'h0089, 16'h0320, 16'h0000, 16'h04b0, 16'h0012}, 5, 0, 1201, 1);
        run('{16'h0089, 16'h0520, 16'h0000, 16'h04b0, 16'h0013}, 5, 0, 1200, 1);
        run('{16'h0089, 16'h0620, 16'h0000, 16'h04b0, 16'h0014}, 5, 0, 1200, 0);
    endtask
    initial begin
        repeat (16) @(posedge MCLK);
        #1 RST_B = 1'b1;
        t_io_and();
        t_io_zero();
        t_cmp_ge();
        t_cmp_gt();
        t_cmp_other();
        complete_run();
    end
endmodule
bind conditional_jump_unit conditional_jump_unit_checker chk (.MCLK(MCLK), .RST_B(RST_B),
    .WORD_VALID(WORD_VALID), .WORD_DATA(WORD_DATA), .CMD_ADDR(CMD_ADDR), .REG_READ(REG_READ),
    .REG_DATA_VALID(REG_DATA_VALID), .NEXT_PC(NEXT_PC), .PC_LOAD(PC_LOAD),
    .JUMP_TAKEN(JUMP_TAKEN), .BUSY(BUSY));
`default_nettype wire
